// ---- core/led_pkg.sv ----
// constants, types and helpers for the led matrix pwm and key scan block
// Functional notes
// - frame end raises led frame request
// - disable waits for current frame end
// - key scan frame end raises request
// - per-channel enables, bit 1 B, bit 0 A
// - enables always accessible; global off darkens segments
// - manual mode: channel runs only when enabled
// - auto mode ignores channel enable bits
// - duty writable manual only; transients during loading
// - waveforms per common: code 0 eight, 7 one
// - three-bit pwm clock source select
// - config writes only manual or globally disabled
// - mode bit: 0 manual, 1 auto
// - key rows 0..k active, capped at 19
// - global off: lines inactive, clocks stopped
// - stop after both frames; re-enable keeps running
// - control one bit 1 enables key pull-ups
// - control bit enables hardware key scan
// - key scan delay code to pwm periods
// - two-bit pull-up timing within common slot
// - common polarity: 0 low, 1 high active
// - segment polarity: 0 high, 1 low active
// - read-only index of current common line
// - common count select: lines 0..m driven
// - capture key columns when common goes inactive
// - auto duty from 128-byte ram, 16 columns
package led_pkg;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [11:0] OFS_CHAN_EN = 12'h000;
  localparam logic [11:0] OFS_DUTY_A = 12'h010;
  localparam logic [11:0] OFS_DUTY_B = 12'h020;
  localparam logic [11:0] OFS_CTL0 = 12'h030;
  localparam logic [11:0] OFS_CTL1 = 12'h034;
  localparam logic [11:0] OFS_CTL2 = 12'h038;
  localparam logic [11:0] OFS_CTL3 = 12'h03C;
  localparam logic [11:0] OFS_CTL4 = 12'h040;
  localparam logic [11:0] OFS_KEY = 12'h100;
  localparam logic [11:0] OFS_RAM = 12'h200;
  // ==========================================================
  // reset values and masks
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [2:0] CTL4_RST = 3'h2;
  localparam logic [7:0] CTL0_MASK = 8'hFD;
  // ==========================================================
  // field positions
  localparam int WAVES_LSB = 5;
  localparam int CLKSEL_LSB = 2;
  localparam int AUTO_BIT = 0;
  localparam int ROWS_LSB = 3;
  localparam int GE_BIT = 2;
  localparam int PULLUP_BIT = 1;
  localparam int SCAN_BIT = 0;
  localparam int DELAY_LSB = 4;
  localparam int PTIME_LSB = 2;
  localparam int COMPOL_BIT = 1;
  localparam int SEGPOL_BIT = 0;
  // ==========================================================
  // sizes and counts
  localparam int NUM_MODULES = 4;
  localparam int NUM_CHANNELS = 8;
  localparam int NUM_COMMONS = 16;
  localparam int NUM_ROWS = 20;
  localparam int RAM_DEPTH = 128;
  localparam logic [4:0] MAX_ROW = 5'h13;
  localparam logic [3:0] LOAD_DONE = 4'h9;
  localparam logic [9:0] DELAY_BASE_LO = 10'h005;
  localparam logic [9:0] DELAY_BASE_HI = 10'h004;
  localparam logic [7:0] PULL_Q1 = 8'h40;
  localparam logic [7:0] PULL_HALF = 8'h80;
  localparam logic [7:0] PULL_Q3 = 8'hC0;
  // ==========================================================
  // types
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_SLOT = 3'h2,
    ST_GAP = 3'h4
  } seq_state_t;
  // ==========================================================
  // helpers
  function automatic logic [9:0] scan_delay(input logic [3:0] code);
    logic [9:0] base;
    base = code[3] ? DELAY_BASE_HI : DELAY_BASE_LO;
    return 10'(base << code[2:0]);
  endfunction : scan_delay

  function automatic logic group_hit(input logic [11:0] a,
                                     input logic [11:0] base);
    return a[11:4] == base[11:4];
  endfunction : group_hit
endpackage : led_pkg

// ---- core/ram_port_if.sv ----
// write and read port between the block and its led duty memory
`timescale 1ns/10ps
interface ram_port_if;
  logic wr_en;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic [6:0] rd_addr;
  logic [7:0] rd_data;
  modport ctrl(output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
  modport mem(input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface : ram_port_if

// ---- core/led_ram.sv ----
// led duty memory, one write and one registered read port
`timescale 1ns/10ps
module led_ram
  import led_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  ram_port_if.mem port
);
  logic [7:0] mem_q [RAM_DEPTH];

  always_ff @(posedge ref_clk) begin
    if (port.wr_en) begin
      mem_q[port.wr_addr] <= port.wr_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      port.rd_data <= 8'h00;
    end else begin
      port.rd_data <= mem_q[port.rd_addr];
    end
  end
endmodule : led_ram

// ---- core/pwm_tick_gen.sv ----
// pwm clock enable divider
`timescale 1ns/10ps
module pwm_tick_gen
  import led_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [2:0] clk_select,
  input wire logic run,
  output logic tick
);
  logic [1:0] div_q;
  logic [1:0] div_d;
  wire [1:0] limit = !clk_select[2] ? 2'h0 : (!clk_select[1] ? 2'h1 : 2'h3);

  assign tick = run && (div_q == limit);
  assign div_d = (!run || tick) ? 2'h0 : 2'(div_q + 2'h1);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= 2'h0;
    end else begin
      div_q <= div_d;
    end
  end
endmodule : pwm_tick_gen

// ---- core/led_matrix_pwm_keyscan.sv ----
// led matrix pwm driver with key scan and ahb-lite registers
`timescale 1ns/10ps
module led_matrix_pwm_keyscan
  import led_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic [15:0] common_line,
  output logic [7:0] segment_line,
  output logic [19:0] key_row_output,
  input wire logic [7:0] key_column_input,
  output logic key_pullup_on,
  output logic led_frame_irq,
  output logic key_frame_irq
);
  // ==========================================================
  // registers and state
  logic [1:0] chan_en_q [NUM_MODULES];
  logic [7:0] duty_q [NUM_CHANNELS];
  logic [7:0] key_q [NUM_ROWS];
  logic [7:0] ctl0_q;
  logic [7:0] ctl1_q;
  logic [7:0] ctl2_q;
  logic [3:0] ctl3_q;
  logic [2:0] ctl4_q;
  logic wr_pend_q;
  logic [11:0] wr_addr_q;
  logic [31:0] hrdata_q;
  logic rdy_q;
  seq_state_t state_q;
  seq_state_t state_d;
  logic [4:0] slot_q;
  logic [2:0] wave_q;
  logic [7:0] cnt_q;
  logic [9:0] gap_q;
  logic [3:0] load_q;
  logic [7:0] key_meta_q;
  logic [7:0] key_sync_q;
  logic [15:0] common_q;
  logic [7:0] segment_q;
  logic [19:0] row_q;
  logic pull_q;
  logic led_irq_q;
  logic key_irq_q;
  logic [7:0] rd_d;
  logic [7:0] seg_on;
  logic tick;
  logic pull_hit;

  ram_port_if ram_bus ();

  // ==========================================================
  // control fields
  // mode bit
  wire auto = ctl0_q[AUTO_BIT];
  wire [2:0] waves_code = ctl0_q[WAVES_LSB +: 3];
  wire [2:0] clk_sel = ctl0_q[CLKSEL_LSB +: 3];
  wire [4:0] rows_code = ctl1_q[ROWS_LSB +: 5];
  wire ge = ctl1_q[GE_BIT];
  wire pullup_en = ctl1_q[PULLUP_BIT];
  wire scan_en = ctl1_q[SCAN_BIT];
  wire [3:0] delay_code = ctl2_q[DELAY_LSB +: 4];
  wire [1:0] ptime = ctl2_q[PTIME_LSB +: 2];
  wire com_pol = ctl2_q[COMPOL_BIT];
  wire seg_pol = ctl2_q[SEGPOL_BIT];
  // config open only manual or disabled
  wire cfg_open = !auto || !ge;

  // ==========================================================
  // bus decode
  wire addr_ok = hsel && htrans[1] && hready;
  wire [11:0] ra = haddr[11:0];
  wire [7:0] wdat = hwdata[7:0];
  wire [1:0] wr_idx = wr_addr_q[3:2];
  wire wr_chan_en = wr_pend_q && group_hit(wr_addr_q, OFS_CHAN_EN);
  wire wr_duty_a = wr_pend_q && group_hit(wr_addr_q, OFS_DUTY_A);
  wire wr_duty_b = wr_pend_q && group_hit(wr_addr_q, OFS_DUTY_B);
  wire wr_ctl0 = wr_pend_q && (wr_addr_q == OFS_CTL0);
  wire wr_ctl1 = wr_pend_q && (wr_addr_q == OFS_CTL1);
  wire wr_ctl2 = wr_pend_q && (wr_addr_q == OFS_CTL2);
  wire wr_ctl3 = wr_pend_q && (wr_addr_q == OFS_CTL3);
  wire wr_ctl4 = wr_pend_q && (wr_addr_q == OFS_CTL4);
  wire wr_ram = wr_pend_q && (wr_addr_q[11:9] == OFS_RAM[11:9]);
  wire rd_key = (ra[11:7] == OFS_KEY[11:7]) && (ra[6:2] <= MAX_ROW);

  // ==========================================================
  // sequencer
  // last row index capped at nineteen
  wire [4:0] rows_last = (rows_code > MAX_ROW) ? MAX_ROW : rows_code;
  wire [4:0] led_last = {1'b0, ctl3_q};
  wire [4:0] frame_last =
    (scan_en && rows_last > led_last) ? rows_last : led_last;
  wire [2:0] waves_last = ~waves_code;
  wire [9:0] delay_len = scan_delay(delay_code);
  wire in_slot = state_q == ST_SLOT;
  wire in_gap = state_q == ST_GAP;
  wire wave_end = in_slot && tick && (cnt_q == 8'hFF);
  wire slot_end = wave_end && (wave_q == waves_last);
  wire gap_end = in_gap && tick && (gap_q == 10'(delay_len - 10'h001));
  wire advance = (slot_end && !scan_en) || gap_end;
  wire frame_wrap = advance && (slot_q == frame_last);
  // led frame done at last common
  wire led_done = slot_end && (slot_q == led_last);
  // key frame done at last frame slot
  wire key_done = slot_end && scan_en && (slot_q == frame_last);
  wire led_on = in_slot && (slot_q <= led_last);
  wire row_on = in_slot && scan_en && (slot_q <= rows_last);
  wire slot_start = (state_d == ST_SLOT) && (!in_slot || advance);
  wire load_wr = (load_q != 4'h0) && (load_q != LOAD_DONE);
  wire [2:0] load_idx = 3'(load_q - 4'h1);

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (ge) state_d = ST_SLOT;
      end
      ST_SLOT: begin
        if (slot_end && scan_en) state_d = ST_GAP;
        else if (frame_wrap && !ge) state_d = ST_IDLE;
      end
      ST_GAP: begin
        if (frame_wrap && !ge) state_d = ST_IDLE;
        else if (gap_end) state_d = ST_SLOT;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // pwm tick runs only while active; the ram is always clocked by ref_clk
  pwm_tick_gen u_tick (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .clk_select(clk_sel),
    .run(state_q != ST_IDLE),
    .tick(tick)
  );

  // column per common, a0 b0 .. a3 b3
  assign ram_bus.wr_en = wr_ram;
  assign ram_bus.wr_addr = wr_addr_q[8:2];
  assign ram_bus.wr_data = wdat;
  assign ram_bus.rd_addr = {slot_q[3:0], load_q[2:0]};

  led_ram u_ram (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .port(ram_bus)
  );

  // ==========================================================
  // read mux
  always_comb begin
    rd_d = 8'h00;
    if (group_hit(ra, OFS_CHAN_EN)) rd_d = {6'h00, chan_en_q[ra[3:2]]};
    else if (group_hit(ra, OFS_DUTY_A)) rd_d = duty_q[{ra[3:2], 1'b0}];
    else if (group_hit(ra, OFS_DUTY_B)) rd_d = duty_q[{ra[3:2], 1'b1}];
    else if (ra == OFS_CTL0) rd_d = ctl0_q;
    else if (ra == OFS_CTL1) rd_d = ctl1_q;
    else if (ra == OFS_CTL2) rd_d = ctl2_q;
    else if (ra == OFS_CTL3) rd_d = {slot_q[3:0], ctl3_q};
    else if (ra == OFS_CTL4) rd_d = {5'h00, ctl4_q};
    else if (rd_key) rd_d = key_q[ra[6:2]];
  end

  // ==========================================================
  // pin drive
  // channel gating by mode
  always_comb begin
    for (int k = 0; k < NUM_CHANNELS; k++) begin
      seg_on[k] = led_on && (auto || chan_en_q[k / 2][k % 2]) &&
                  (cnt_q < duty_q[k]);
    end
  end

  always_comb begin
    case (ptime)
      2'h0: pull_hit = (wave_q == waves_last) && (cnt_q >= PULL_Q3);
      2'h1: pull_hit = (wave_q == waves_last) && (cnt_q >= PULL_HALF);
      2'h2: pull_hit = (wave_q == waves_last) && (cnt_q >= PULL_Q1);
      default: pull_hit = (wave_q == 3'h0) && (cnt_q < PULL_Q1);
    endcase
  end

  // ==========================================================
  // bus slave
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      hrdata_q <= 32'h0000_0000;
      rdy_q <= 1'b1;
    end else begin
      wr_pend_q <= addr_ok && hwrite;
      if (addr_ok) wr_addr_q <= ra;
      hrdata_q <= (addr_ok && !hwrite) ? {24'h00_0000, rd_d} : 32'h0000_0000;
      rdy_q <= 1'b1;
    end
  end

  // ==========================================================
  // control registers
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl0_q <= CTL_RST;
      ctl1_q <= CTL_RST;
      ctl2_q <= CTL_RST;
      ctl3_q <= 4'h0;
      ctl4_q <= CTL4_RST;
      for (int n = 0; n < NUM_MODULES; n++) chan_en_q[n] <= 2'h0;
    end else begin
      if (wr_chan_en) chan_en_q[wr_idx] <= wdat[1:0];
      if (wr_ctl0 && cfg_open) ctl0_q <= wdat & CTL0_MASK;
      if (wr_ctl1) ctl1_q <= cfg_open ? wdat :
        {ctl1_q[7:GE_BIT + 1], wdat[GE_BIT], ctl1_q[GE_BIT - 1:0]};
      if (wr_ctl2 && cfg_open) ctl2_q <= wdat;
      if (wr_ctl3 && cfg_open) ctl3_q <= wdat[3:0];
      if (wr_ctl4) ctl4_q <= wdat[2:0];
    end
  end

  // duty from bus in manual, from ram in auto
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int k = 0; k < NUM_CHANNELS; k++) duty_q[k] <= 8'h00;
    end else if (load_wr) begin
      duty_q[load_idx] <= ram_bus.rd_data;
    end else if (!auto && wr_duty_a) begin
      duty_q[{wr_idx, 1'b0}] <= wdat;
    end else if (!auto && wr_duty_b) begin
      duty_q[{wr_idx, 1'b1}] <= wdat;
    end
  end

  // ==========================================================
  // sequence counters
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      slot_q <= 5'h00;
      wave_q <= 3'h0;
      cnt_q <= 8'h00;
      gap_q <= 10'h000;
      load_q <= LOAD_DONE;
    end else begin
      state_q <= state_d;
      if (state_q == ST_IDLE) begin
        slot_q <= 5'h00;
        wave_q <= 3'h0;
        cnt_q <= 8'h00;
        gap_q <= 10'h000;
      end else begin
        if (in_slot && tick) cnt_q <= 8'(cnt_q + 8'h01);
        if (wave_end) wave_q <= slot_end ? 3'h0 : 3'(wave_q + 3'h1);
        if (in_gap && tick) gap_q <= 10'(gap_q + 10'h001);
        else if (slot_end) gap_q <= 10'h000;
        if (advance) slot_q <= frame_wrap ? 5'h00 : 5'(slot_q + 5'h01);
      end
      if (slot_start && auto) load_q <= 4'h0;
      else if (load_q != LOAD_DONE) load_q <= 4'(load_q + 4'h1);
    end
  end

  // ==========================================================
  // key capture and outputs
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      key_meta_q <= 8'h00;
      key_sync_q <= 8'h00;
      for (int r = 0; r < NUM_ROWS; r++) key_q[r] <= 8'h00;
    end else begin
      key_meta_q <= key_column_input;
      key_sync_q <= key_meta_q;
      if (slot_end && row_on) key_q[slot_q] <= key_sync_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      common_q <= 16'hFFFF;
      segment_q <= 8'h00;
      row_q <= 20'hF_FFFF;
      pull_q <= 1'b0;
      led_irq_q <= 1'b0;
      key_irq_q <= 1'b0;
    end else begin
      for (int i = 0; i < NUM_COMMONS; i++) begin
        common_q[i] <= (led_on && slot_q == 5'(i)) ? com_pol : !com_pol;
      end
      for (int r = 0; r < NUM_ROWS; r++) begin
        row_q[r] <= (row_on && slot_q == 5'(r)) ? com_pol : !com_pol;
      end
      segment_q <= seg_on ^ {NUM_CHANNELS{seg_pol}};
      pull_q <= in_slot && scan_en && pullup_en && pull_hit;
      led_irq_q <= led_done;
      key_irq_q <= key_done;
    end
  end

  assign hreadyout = rdy_q;
  assign hrdata = hrdata_q;
  assign hresp = 1'b0;
  assign common_line = common_q;
  assign segment_line = segment_q;
  assign key_row_output = row_q;
  assign key_pullup_on = pull_q;
  assign led_frame_irq = led_irq_q;
  assign key_frame_irq = key_irq_q;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_led_irq_pulse: assert property (led_irq_q |=> !led_irq_q)
    else $error("led frame request longer than one cycle");
  a_led_frame_irq: assert property (led_done |=> led_irq_q)
    else $error("led frame end without request");
  a_key_irq_cause: assert property (
    key_irq_q |-> $past(scan_en) && $past(slot_end))
    else $error("key frame request without scan frame end");
  a_stop_at_frame: assert property (
    (state_q == ST_IDLE && $past(state_q) != ST_IDLE)
      |-> $past(frame_wrap) && !$past(ge))
    else $error("block stopped before frame end");
  a_reenable_runs: assert property (
    (state_q != ST_IDLE && ge) |=> state_q != ST_IDLE)
    else $error("block stopped while enabled");
  a_idle_dark: assert property (
    (state_q == ST_IDLE)[*2] ##0 $stable(ctl2_q)
      |-> common_line == {16{!com_pol}} &&
          segment_line == {8{seg_pol}})
    else $error("lines active while stopped");
  a_chan_gated: assert property (
    (!auto && !chan_en_q[0][0]) |=> segment_line[0] == $past(seg_pol))
    else $error("disabled channel drove its segment");
  a_cfg_locked: assert property (
    (wr_ctl0 && !cfg_open) |=> $stable(ctl0_q))
    else $error("config changed while locked");
  a_key_capture: assert property (
    (slot_end && row_on) |=> key_q[$past(slot_q)] == $past(key_sync_q))
    else $error("key columns not captured");

  c_led_frame: cover property (led_irq_q);
  c_key_frame: cover property (key_irq_q);
  c_auto_load: cover property (auto && load_q == 4'h8);
  c_stop_idle: cover property (in_gap ##1 state_q == ST_IDLE);
endmodule : led_matrix_pwm_keyscan

// ---- tb/key_matrix_model.sv ----
// key matrix model driving the key column inputs
`timescale 1ns/10ps
module key_matrix_model (
  input wire logic ref_clk,
  input wire logic [19:0] key_row_output,
  input wire logic key_pullup_on,
  input wire logic row_on_level,
  input wire logic [7:0] key_pattern,
  output logic [7:0] key_column_input
);
  // ==========================================================
  // column drive
  initial key_column_input = 8'h00;
  // keys seen only while row 0 is active
  always @(posedge ref_clk) begin
    if (key_row_output[0] === row_on_level) begin
      key_column_input <= key_pattern;
    end else if (key_pullup_on === 1'b1) begin
      key_column_input <= 8'hFF;
    end else begin
      key_column_input <= ~key_column_input;
    end
  end
endmodule : key_matrix_model

// ---- tb/tb.sv ----
// self-checking bench for the led matrix pwm and key scan block
`timescale 1ns/10ps
module tb;
  import led_pkg::*;
  logic ref_clk, rst_b, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] common_line;
  logic [7:0] segment_line, key_column_input, pat;
  logic [19:0] key_row_output;
  logic key_pullup_on, led_frame_irq, key_frame_irq, cpol, spol;
  logic [1:0] en[4];
  logic [7:0] modes[3] = '{8'hE0, 8'hD0, 8'hF8};
  int periods[3] = '{256, 1024, 1024};
  int mismatches, n_compared, cycles, seed, npull, p;
  int duty[8], cnt[8];
  assign hready = hreadyout;
  // ==========================================================
  // design and far side
  led_matrix_pwm_keyscan DUT (.ref_clk(ref_clk), .rst_b(rst_b),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .common_line(common_line), .segment_line(segment_line),
    .key_row_output(key_row_output),
    .key_column_input(key_column_input), .key_pullup_on(key_pullup_on),
    .led_frame_irq(led_frame_irq), .key_frame_irq(key_frame_irq));
  key_matrix_model keys (.ref_clk(ref_clk),
    .key_row_output(key_row_output), .key_pullup_on(key_pullup_on),
    .row_on_level(cpol), .key_pattern(pat),
    .key_column_input(key_column_input));
  // ==========================================================
  // clock and timeout
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      final_report();
    end
  end
  // ==========================================================
  // tasks
  task automatic final_report();
    if (mismatches == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic ahb(input logic wr, input int a, input logic [7:0] wd);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {20'h0_0000, a[11:0]};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, wd};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  task automatic wait_irq(input bit key, output int t);
    t = 0;
    npull = 0;
    do begin
      @(posedge ref_clk);
      #1;
      t++;
      npull += (key_pullup_on === 1'b1);
    end while ((key ? key_frame_irq : led_frame_irq) !== 1'b1 && t < 3000);
    if (t >= 3000) begin
      chk("frame request wait", 32'h0000_0000, 32'h0000_0001);
    end
  endtask : wait_irq
  task automatic count_seg();
    cnt = '{default: 0};
    repeat (256) begin
      @(posedge ref_clk);
      #1;
      for (int i = 0; i < 8; i++) cnt[i] += (segment_line[i] === 1'b1);
    end
  endtask : count_seg
  task automatic idle_chk();
    chk("idle common", cpol ? 32'h0000_0000 : 32'h0000_FFFF,
        common_line);
    chk("idle segment", spol ? 32'h0000_00FF : 32'h0000_0000,
        segment_line);
  endtask : idle_chk
  task automatic stop_led();
    ahb(1'b1, OFS_CTL1, 8'h00);
    wait_irq(1'b0, p);
    repeat (600) @(posedge ref_clk);
    #1;
    idle_chk();
  endtask : stop_led
  // ==========================================================
  // main sequence
  initial begin
    {hsel, hwrite, haddr, htrans, hwdata, cpol, spol} = '0;
    hsize = 3'b010;
    rst_b = 1'b0;
    seed = 32'h5f57a48a;
    pat = 8'($random(seed));
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    foreach (modes[i]) begin
      ahb(1'b0, OFS_CTL0 + 4 * i, 8'h00);
      chk("reset ctl", 32'h0000_0000, rd);
    end
    ahb(1'b0, OFS_CTL4, 8'h00);
    chk("reset ctl4", 32'h0000_0002, rd);
    ahb(1'b1, 12'h0FC, 8'h5A);
    ahb(1'b0, 12'h0FC, 8'h00);
    chk("unmapped", 32'h0000_0000, rd);
    for (int n = 0; n < 4; n++) begin
      en[n] = 2'($random(seed));
      duty[2 * n] = $random(seed) & 255;
      duty[2 * n + 1] = $random(seed) & 255;
      ahb(1'b1, OFS_CHAN_EN + 4 * n, {6'h00, en[n]});
      ahb(1'b1, OFS_DUTY_A + 4 * n, 8'(duty[2 * n]));
      ahb(1'b1, OFS_DUTY_B + 4 * n, 8'(duty[2 * n + 1]));
      ahb(1'b0, OFS_CHAN_EN + 4 * n, 8'h00);
      chk("chan enable", {30'h0, en[n]}, rd);
      ahb(1'b0, OFS_DUTY_B + 4 * n, 8'h00);
      chk("duty b", 32'(duty[2 * n + 1]), rd);
    end
    ahb(1'b1, OFS_CTL0, 8'hE0);
    ahb(1'b1, OFS_CTL1, 8'h04);
    wait_irq(1'b0, p);
    count_seg();
    for (int i = 0; i < 8; i++) begin
      chk("manual duty", en[i / 2][i % 2] ? duty[i] : 0, cnt[i]);
    end
    foreach (modes[k]) begin
      stop_led();
      ahb(1'b1, OFS_CTL0, modes[k]);
      ahb(1'b1, OFS_CTL1, 8'h04);
      wait_irq(1'b0, p);
      wait_irq(1'b0, p);
      chk("frame period", periods[k], p);
    end
    ahb(1'b1, OFS_CTL1, 8'h00);
    ahb(1'b1, OFS_CTL1, 8'h04);
    wait_irq(1'b0, p);
    repeat (20) @(posedge ref_clk);
    #1;
    chk("re-enabled common", 32'h0000_FFFE, common_line);
    stop_led();
    ahb(1'b1, OFS_CTL2, 8'h03);
    cpol = 1'b1;
    spol = 1'b1;
    @(posedge ref_clk);
    #1;
    idle_chk();
    chk("idle rows", 32'h0000_0000, key_row_output);
    ahb(1'b1, OFS_CTL0, 8'hE0);
    ahb(1'b1, OFS_CTL1, 8'h04);
    wait_irq(1'b0, p);
    count_seg();
    for (int i = 0; i < 8; i++) begin
      chk("low duty", en[i / 2][i % 2] ? 256 - duty[i] : 256, cnt[i]);
    end
    stop_led();
    ahb(1'b1, OFS_CTL2, 8'h00);
    cpol = 1'b0;
    spol = 1'b0;
    // key frame with delay code 8
    ahb(1'b1, OFS_CTL2, 8'h8C);
    ahb(1'b1, OFS_CTL1, 8'h07);
    wait_irq(1'b1, p);
    wait_irq(1'b1, p);
    chk("key frame period", 32'd260, p);
    chk("pullup cycles", 32'd64, npull);
    ahb(1'b0, OFS_KEY, 8'h00);
    chk("key data", {24'h00_0000, pat}, rd);
    stop_led();
    // two commons, three rows, delay code 0
    ahb(1'b1, OFS_CTL2, 8'h00);
    ahb(1'b1, OFS_CTL3, 8'h01);
    ahb(1'b1, OFS_CTL1, 8'h17);
    wait_irq(1'b1, p);
    wait_irq(1'b1, p);
    chk("rows frame period", 32'd783, p);
    chk("late pullup cycles", 32'd192, npull);
    ahb(1'b0, OFS_CTL3, 8'h00);
    chk("common index", 32'h0000_0021, rd);
    ahb(1'b0, OFS_KEY + 4, 8'h00);
    chk("pulled key row", 32'h0000_00FF, rd);
    stop_led();
    ahb(1'b1, OFS_CTL3, 8'h00);
    for (int i = 0; i < 8; i++) begin
      duty[i] = $random(seed) & 255;
      ahb(1'b1, OFS_RAM + 4 * i, 8'(duty[i]));
    end
    for (int n = 0; n < 4; n++) ahb(1'b1, OFS_CHAN_EN + 4 * n, 8'h00);
    ahb(1'b1, OFS_CTL2, 8'h00);
    ahb(1'b1, OFS_CTL0, 8'hE1);
    ahb(1'b1, OFS_CTL1, 8'h04);
    wait_irq(1'b0, p);
    count_seg();
    for (int i = 0; i < 8; i++) chk("auto duty", duty[i], cnt[i]);
    ahb(1'b1, OFS_CTL0, 8'h00);
    ahb(1'b0, OFS_CTL0, 8'h00);
    chk("locked ctl0", 32'h0000_00E1, rd);
    final_report();
  end
endmodule : tb
